// file: bench/pd_message_format_checker_bench.sv
module pd_message_format_checker_bench import pdmfc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic resetn, tx_start, tx_sop, tx_hdr_valid, tx_obj_valid, tx_end;
    logic tx_src_cap, tx_cap_solicited, discovery, power_role, data_role;
    logic cable_plug_role, bmc_in_use, swap_first_psrdy, contract_present;
    logic supply_not_safe, swapped, chk, rx_end;
    logic [15:0] tx_hdr, g, pg;
    logic [31:0] tx_obj;
    logic [4:0] cfg_cap_flags;
    logic [2:0] rx_msg_id;
    logic [MAX_OBJ-1:0][31:0] cfg, base, objs;
    logic [NVIOL-1:0] viol, exp_v;
    logic [NVIOL-1:0] q[$];
    logic [3:0] rsv[3] = '{MT_RSV_LO, MT_RSV_E, MT_RSV_F};
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'hfd7c;

    pdmfc_checker #(.RESP_LIMIT(16'h0014), .PING_PERIOD(24'h000032)) dut (
        .clk(clk), .resetn(resetn), .tx_start(tx_start), .tx_sop(tx_sop),
        .tx_hdr_valid(tx_hdr_valid), .tx_hdr(tx_hdr), .tx_obj_valid(tx_obj_valid),
        .tx_obj(tx_obj), .tx_end(tx_end), .tx_src_cap(tx_src_cap),
        .tx_cap_solicited(tx_cap_solicited), .discovery(discovery), .rx_end(rx_end),
        .rx_msg_id(rx_msg_id), .power_role(power_role), .data_role(data_role),
        .cable_plug_role(cable_plug_role), .bmc_in_use(bmc_in_use),
        .swap_first_psrdy(swap_first_psrdy), .contract_present(contract_present),
        .supply_not_safe(supply_not_safe), .swapped(swapped),
        .cfg_cap_flags(cfg_cap_flags), .cfg_pdo(cfg), .viol(viol)
    );

    pdmfc_partner partner (.clk(clk), .rx_end(rx_end), .rx_msg_id(rx_msg_id));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [NVIOL-1:0] b(input int k);
        b = '0;
        b[k] = 1'b1;
    endfunction

    function automatic logic [15:0] mk(input logic [2:0] n, input logic [3:0] t);
        return {1'b0, n, 3'h0, 1'b1, REV_ACK, 1'b0, 1'b0, t};
    endfunction

    function automatic logic [31:0] fx(input logic [4:0] f, input logic [1:0] pk,
                                       input logic [9:0] v, input logic [9:0] c);
        return {PDO_FIXED, f, 3'h0, pk, v, c};
    endfunction

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // flags are sticky, so one look per message is enough
    always @(posedge clk) begin
        if (chk === 1'b1) begin
            exp_v = q.pop_front();
            checks_done++;
            if (viol !== exp_v) begin
                $display("[FAIL] viol expected %h seen %h", exp_v, viol);
                fail_count++;
            end
        end
    end

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic note(input logic [NVIOL-1:0] e);
        q.push_back(e);
        chk = 1'b1;
        step;
        chk = 1'b0;
    endtask

    task automatic msg(input logic sop, input logic [15:0] h, input int n,
                       input logic [NVIOL-1:0] e);
        step;
        tx_start = 1'b1;
        tx_sop = sop;
        step;
        tx_start = 1'b0;
        tx_hdr_valid = 1'b1;
        tx_hdr = h;
        step;
        tx_hdr_valid = 1'b0;
        tx_hdr = ~h;
        for (int i = 0; i < n; i++) begin
            step;
            tx_obj_valid = 1'b1;
            tx_obj = objs[i];
            step;
            tx_obj_valid = 1'b0;
            tx_obj = ~objs[i];
        end
        step;
        tx_end = 1'b1;
        step;
        tx_end = 1'b0;
        step;
        note(e);
    endtask

    task automatic ack(input logic sop, input logic [15:0] h, input logic [2:0] off,
                       input int dly, input int n, input logic [NVIOL-1:0] e);
        logic [2:0] id;
        id = 3'($random(seed));
        partner.send(id);
        repeat (dly) @(posedge clk);
        h[ID_MSB:ID_LSB] = id + off;
        msg(sop, h, n, e);
    endtask

    task automatic caps(input int n, input logic [NVIOL-1:0] e);
        tx_src_cap = 1'b1;
        msg(1'b1, mk(3'(n), MT_SRC_CAP), n, e);
        tx_src_cap = 1'b0;
        objs = cfg;
    endtask

    initial begin
        {tx_start, tx_sop, tx_hdr_valid, tx_obj_valid, tx_end, tx_src_cap} = '0;
        {tx_cap_solicited, discovery, swap_first_psrdy, contract_present} = '0;
        {supply_not_safe, swapped, chk, cable_plug_role, data_role, resetn} = '0;
        power_role = 1'b1;
        bmc_in_use = 1'b1;
        tx_hdr = '0;
        tx_obj = '0;
        cfg_cap_flags = 5'h0A;
        base = '0;
        base[0] = fx(5'h0A, 2'h1, VOLT_5V, 10'h12C);
        base[1] = fx(5'h00, 2'h0, 10'h0B4, 10'h0C8);
        base[2] = {PDO_BATTERY, 10'h0F0, 10'h0B4, 10'h064};
        base[3] = {PDO_VARIABLE, 10'h0F0, 10'h0B4, 10'h032};
        cfg = base;
        objs = base;
        g = mk(3'h0, MT_GOODCRC);
        pg = mk(3'h0, MT_PING);
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        ack(1'b1, g, 3'h0, 3, 0, '0);
        ack(1'b1, g | 16'h8000, 3'h0, 3, 0, b(V_R2));
        ack(1'b1, g, 3'h0, 3, 1, b(V_R3) | b(V_R12));
        ack(1'b1, g, 3'h1, 3, 0, b(V_R4));
        ack(1'b1, g ^ 16'h0100, 3'h0, 3, 0, b(V_R5));
        swap_first_psrdy = 1'b1;
        ack(1'b1, g ^ 16'h0100, 3'h0, 3, 0, '0);
        swap_first_psrdy = 1'b0;
        ack(1'b0, g, 3'h0, 3, 0, b(V_R6));
        ack(1'b0, g ^ 16'h0100, 3'h0, 3, 0, '0);
        ack(1'b0, g ^ 16'h0120, 3'h0, 3, 0, b(V_R10));
        ack(1'b1, g ^ 16'h00C0, 3'h0, 3, 0, b(V_R7));
        ack(1'b1, g ^ 16'h0040, 3'h0, 3, 0, b(V_R7) | b(V_R8));
        bmc_in_use = 1'b0;
        ack(1'b1, g ^ 16'h0040, 3'h0, 3, 0, b(V_R7));
        bmc_in_use = 1'b1;
        ack(1'b1, g ^ 16'h0020, 3'h0, 3, 0, b(V_R9));
        ack(1'b1, g ^ 16'h0010, 3'h0, 3, 0, b(V_R10));
        ack(1'b1, g, 3'h0, 18, 0, '0);
        ack(1'b1, g, 3'h0, 19, 0, b(V_R11));
        ack(1'b1, g, 3'h0, 40, 0, b(V_R11));
        $display("test acknowledge done");
        msg(1'b1, mk(3'h0, 4'h3), 1, b(V_R12));
        for (int i = 0; i < 3; i++) begin
            msg(1'b1, mk(3'h0, rsv[i]), 0, b(V_R24));
        end
        msg(1'b1, pg, 0, b(V_R13));
        contract_present = 1'b1;
        msg(1'b1, pg, 0, '0);
        supply_not_safe = 1'b1;
        repeat (60) step;
        note(b(V_R14));
        msg(1'b1, pg, 0, '0);
        supply_not_safe = 1'b0;
        swapped = 1'b1;
        repeat (60) step;
        note(b(V_R14));
        swapped = 1'b0;
        $display("test ping done");
        caps(4, '0);
        caps(4, b(V_R23));
        tx_cap_solicited = 1'b1;
        caps(4, '0);
        tx_cap_solicited = 1'b0;
        discovery = 1'b1;
        caps(4, '0);
        tx_src_cap = 1'b1;
        msg(1'b1, mk(3'h1, 4'h4), 0, b(V_R15));
        tx_src_cap = 1'b0;
        objs[0][VOLT_MSB:VOLT_LSB] = 10'h0B4;
        caps(1, b(V_R16));
        objs[0][RSV_LSB] = 1'b1;
        caps(1, b(V_R16));
        objs[0][FLG_LSB] = 1'b1;
        caps(1, b(V_R17));
        objs[0][CUR_LSB] = 1'b1;
        caps(1, b(V_R18));
        objs[1][PEAK_LSB] = 1'b1;
        caps(2, b(V_R18));
        objs[1][PDO_T_MSB:PDO_T_LSB] = PDO_ILLEGAL;
        caps(2, b(V_R19));
        objs[1][RSV_MSB] = 1'b1;
        caps(2, b(V_R21));
        objs[1][VOLT_MSB:VOLT_LSB] = 10'h0C8;
        caps(2, b(V_R21));
        objs[2][VMAX_LSB] = 1'b1;
        caps(4, b(V_R22));
        objs[3][CUR_LSB] = 1'b1;
        caps(4, b(V_R22));
        cfg[1] = base[3];
        cfg[2] = base[2];
        objs = cfg;
        caps(3, b(V_R20));
        cfg = base;
        cfg[3] = base[2];
        objs = cfg;
        caps(4, b(V_R20));
        cfg = base;
        objs = cfg;
        caps(4, '0);
        $display("test capabilities done");
        resetn = 1'b0;
        step;
        note('0);
        resetn = 1'b1;
        discovery = 1'b0;
        caps(4, '0);
        $display("test reset done");
        conclude;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[FAIL] run cycles expected 20000 max seen more");
        conclude;
    end
endmodule

// file: bench/pdmfc_partner.sv
module pdmfc_partner (
    input wire logic clk,
    output logic rx_end,
    output logic [2:0] rx_msg_id
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        rx_end = 1'b0;
        rx_msg_id = 3'h0;
    end

    // id is not held after the frame, so a stale value is never trusted
    task automatic send(input logic [2:0] id);
        @(posedge clk);
        #1;
        rx_end = 1'b1;
        rx_msg_id = id;
        @(posedge clk);
        #1;
        rx_end = 1'b0;
        rx_msg_id = ~id;
    endtask
endmodule

// file: rtl/pdmfc_checker.sv
// Functional notes
// R1: zero object count and type 0001b marks a header as an acknowledgement.
// R2: acknowledgement header bit 15 must be zero.
// R3: acknowledgement carries no payload after its header.
// R4: acknowledgement identifier equals that of the partner message acknowledged.
// R5: SOP acknowledgement bit 8 shows power role; first swap ready exempt.
// R6: non-SOP acknowledgement bit 8 shows the expected cable plug role.
// R7: acknowledgement revision field bits 7:6 must be 01b.
// R8: with BMC signalling, revision field never 00b.
// R9: SOP acknowledgement bit 5 shows the current data role.
// R10: bit 5 zero for non-SOP, bit 4 always zero.
// R11: acknowledgement starts within the transmit response limit of partner end.
// R12: control messages carry no payload after the header.
// R13: a Ping is sent only while an explicit contract exists.
// R14: source pings periodically off safe default voltage or when swapped.
// R15: source capabilities has type 0001b and at least one object.
// R16: first object is fixed, B24:B22 zero, voltage 5V.
// R17: first object flags B29:B25 match configured capabilities.
// R18: fixed objects peak and current fields match configuration.
// R19: object type 11b is never allowed.
// R20: later objects ordered fixed, battery, variable, voltages strictly rising.
// R21: later fixed objects have B29:B22 zero and configured voltage.
// R22: battery and variable objects match configured voltages and current.
// R23: unsolicited capabilities outside discovery must differ from the previous.
// R24: SOP control message types 0000b, 1110b, 1111b are reserved.
// R25: one flag per failed check, latched until the next message starts.
module pdmfc_checker
    import pdmfc_pkg::*;
#(
    parameter logic [15:0] RESP_LIMIT = 16'(RESP_LIMIT_CYC),
    parameter logic [23:0] PING_PERIOD = 24'(PING_PERIOD_CYC)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tx_start,
    input wire logic tx_sop,
    input wire logic tx_hdr_valid,
    input wire logic [15:0] tx_hdr,
    input wire logic tx_obj_valid,
    input wire logic [31:0] tx_obj,
    input wire logic tx_end,
    input wire logic tx_src_cap,
    input wire logic tx_cap_solicited,
    input wire logic discovery,
    input wire logic rx_end,
    input wire logic [2:0] rx_msg_id,
    input wire logic power_role,
    input wire logic data_role,
    input wire logic cable_plug_role,
    input wire logic bmc_in_use,
    input wire logic swap_first_psrdy,
    input wire logic contract_present,
    input wire logic supply_not_safe,
    input wire logic swapped,
    input wire logic [4:0] cfg_cap_flags,
    input wire logic [MAX_OBJ-1:0][31:0] cfg_pdo,
    output logic [NVIOL-1:0] viol
);
    logic in_msg;
    logic in_ack;
    logic in_ctrl;
    logic in_cap;
    logic [2:0] obj_idx;
    logic [31:0] prev_obj;
    logic [MAX_OBJ-1:0][31:0] last_cap;
    logic [2:0] last_cap_cnt;
    logic last_cap_valid;
    logic same_as_last;
    logic [2:0] id_expect;
    logic resp_run;
    logic resp_late;
    logic [15:0] resp_cnt;
    logic [23:0] ping_cnt;
    logic [NVIOL-1:0] set_vec;

    pdmfc_pdo_if pdo ();

    // header decode
    wire [2:0] ndo = hdr_ndo(tx_hdr);
    wire [3:0] mtype = hdr_type(tx_hdr);
    wire [1:0] rev = tx_hdr[REV_MSB:REV_LSB];
    wire is_ctrl = ndo == NDO_NONE;
    wire is_ack = is_ctrl && (mtype == MT_GOODCRC); // [R1]
    wire is_ping = is_ctrl && (mtype == MT_PING);
    wire is_cap = !is_ctrl && (mtype == MT_SRC_CAP);
    wire mtype_rsv = (mtype == MT_RSV_LO) || (mtype == MT_RSV_E) || (mtype == MT_RSV_F);
    wire hv_ack = tx_hdr_valid && is_ack;
    wire ping_now = tx_hdr_valid && is_ping;

    // object stream
    wire obj_ok = obj_idx != OBJ_LAST;
    wire cap_obj = tx_obj_valid && in_cap && obj_ok;
    wire [2:0] next_obj_idx = obj_ok ? obj_idx + 3'h1 : obj_idx;
    wire obj_matches_last = last_cap_valid && (tx_obj == last_cap[obj_idx]);
    wire cap_exempt = tx_cap_solicited || discovery;
    wire cap_repeat = tx_end && in_cap && last_cap_valid && same_as_last
        && (obj_idx == last_cap_cnt);

    // periodic ping watch
    wire ping_needed = supply_not_safe || swapped;
    wire ping_due = ping_needed && !ping_now && (ping_cnt == PING_PERIOD - 24'h1);

    assign pdo.obj = tx_obj;
    assign pdo.prev = prev_obj;
    assign pdo.expect_pdo = cfg_pdo[obj_idx];
    assign pdo.cap_flags = cfg_cap_flags;
    assign pdo.first = obj_idx == 3'h0;
    // ordering starts at the second object after the first
    assign pdo.has_prev = obj_idx > 3'h1;

    pdmfc_pdo_check u_pdo_check (
        .p(pdo)
    );

    always_comb begin
        set_vec = '0;
        set_vec[V_R2] = hv_ack && tx_hdr[HDR_RSV_BIT]; // [R2]
        set_vec[V_R3] = tx_obj_valid && in_ack; // [R3]
        set_vec[V_R4] = hv_ack && (tx_hdr[ID_MSB:ID_LSB] != id_expect); // [R4]
        set_vec[V_R5] = hv_ack && tx_sop && !swap_first_psrdy
            && (tx_hdr[ROLE_BIT] != power_role); // [R5]
        set_vec[V_R6] = hv_ack && !tx_sop && (tx_hdr[ROLE_BIT] != cable_plug_role); // [R6]
        set_vec[V_R7] = hv_ack && (rev != REV_ACK); // [R7]
        set_vec[V_R8] = tx_hdr_valid && bmc_in_use && (rev == REV_NEVER_BMC); // [R8]
        set_vec[V_R9] = hv_ack && tx_sop && (tx_hdr[DROLE_BIT] != data_role); // [R9]
        set_vec[V_R10] = hv_ack && ((!tx_sop && tx_hdr[DROLE_BIT]) || tx_hdr[RSV4_BIT]); // [R10]
        set_vec[V_R11] = hv_ack && resp_late; // [R11]
        set_vec[V_R12] = tx_obj_valid && in_ctrl; // [R12]
        set_vec[V_R13] = ping_now && !contract_present; // [R13]
        set_vec[V_R14] = ping_due; // [R14]
        set_vec[V_R15] = tx_hdr_valid && tx_src_cap && (is_ctrl || mtype != MT_SRC_CAP); // [R15]
        set_vec[V_R16] = cap_obj && pdo.err_first; // [R16]
        set_vec[V_R17] = cap_obj && pdo.err_flags; // [R17]
        set_vec[V_R18] = cap_obj && pdo.err_fixed; // [R18]
        set_vec[V_R19] = cap_obj && pdo.err_kind; // [R19]
        set_vec[V_R20] = cap_obj && pdo.err_order; // [R20]
        set_vec[V_R21] = cap_obj && pdo.err_fixed_rsv; // [R21]
        set_vec[V_R22] = cap_obj && pdo.err_range; // [R22]
        set_vec[V_R23] = cap_repeat && !cap_exempt; // [R23]
        set_vec[V_R24] = tx_hdr_valid && is_ctrl && tx_sop && mtype_rsv; // [R24]
    end

    // a set in the clearing cycle wins
    wire [NVIOL-1:0] next_viol = (tx_start ? '0 : viol) | set_vec; // [R25]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            viol <= '0;
        end else begin
            viol <= next_viol;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_msg <= 1'b0;
            in_ack <= 1'b0;
            in_ctrl <= 1'b0;
            in_cap <= 1'b0;
        end else if (tx_start) begin
            in_msg <= 1'b1;
            in_ack <= 1'b0;
            in_ctrl <= 1'b0;
            in_cap <= 1'b0;
        end else if (tx_hdr_valid && in_msg) begin
            in_ack <= is_ack;
            in_ctrl <= is_ctrl;
            in_cap <= is_cap;
        end else if (tx_end) begin
            in_msg <= 1'b0;
            in_ack <= 1'b0;
            in_ctrl <= 1'b0;
            in_cap <= 1'b0;
        end
    end

    // objects of the current message, kept for order and repeat checks
    always_ff @(posedge clk) begin
        if (!resetn) begin
            obj_idx <= 3'h0;
            prev_obj <= '0;
            same_as_last <= 1'b0;
        end else if (tx_start) begin
            obj_idx <= 3'h0;
            same_as_last <= 1'b1;
        end else if (cap_obj) begin
            obj_idx <= next_obj_idx;
            prev_obj <= tx_obj;
            same_as_last <= same_as_last && obj_matches_last; // [R23]
        end
    end

    // overwritten in place, compared just before each write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_cap <= '0;
            last_cap_cnt <= 3'h0;
            last_cap_valid <= 1'b0;
        end else begin
            if (cap_obj) begin
                last_cap[obj_idx] <= tx_obj;
            end
            if (tx_end && in_cap) begin
                last_cap_cnt <= obj_idx;
                last_cap_valid <= 1'b1;
            end
        end
    end

    // response timer from the partner's last bit to our next first bit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            resp_run <= 1'b0;
            resp_late <= 1'b0;
            resp_cnt <= 16'h0;
            id_expect <= 3'h0;
        end else if (rx_end) begin
            resp_run <= 1'b1;
            resp_late <= 1'b0;
            resp_cnt <= 16'h0;
            id_expect <= rx_msg_id; // [R4]
        end else if (tx_start) begin
            resp_run <= 1'b0;
            // count is one behind the cycles elapsed, so a start at exactly the limit is on time
            resp_late <= resp_run && (resp_cnt >= RESP_LIMIT); // [R11]
        end else if (resp_run && resp_cnt <= RESP_LIMIT) begin
            resp_cnt <= resp_cnt + 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ping_cnt <= 24'h0;
        end else if (!ping_needed || ping_now || ping_due) begin
            ping_cnt <= 24'h0;
        end else begin
            ping_cnt <= ping_cnt + 24'h1; // [R14]
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_r25_hold;
        !tx_start |=> (viol & $past(viol)) == $past(viol);
    endproperty
    a_r25_hold: assert property (p_r25_hold) else $error("flag dropped mid message"); // [R25]

    property p_r2;
        tx_hdr_valid && is_ack && tx_hdr[HDR_RSV_BIT] |=> viol[V_R2];
    endproperty
    a_r2: assert property (p_r2) else $error("reserved bit 15 not flagged"); // [R2]

    sequence s_partner_done;
        rx_end ##1 !rx_end[*1];
    endsequence
    sequence s_wrong_id;
        tx_hdr_valid && is_ack && tx_hdr[ID_MSB:ID_LSB] != id_expect;
    endsequence
    property p_r4;
        s_wrong_id |=> viol[V_R4];
    endproperty
    a_r4: assert property (p_r4) else $error("wrong ack identifier not flagged"); // [R4]

    property p_r4_take;
        s_partner_done |-> id_expect == $past(rx_msg_id);
    endproperty
    a_r4_take: assert property (p_r4_take) else $error("partner identifier not kept"); // [R4]

    property p_r7;
        tx_hdr_valid && is_ack && rev != 2'h1 |=> viol[V_R7];
    endproperty
    a_r7: assert property (p_r7) else $error("ack revision not flagged"); // [R7]

    sequence s_late_start;
        tx_start && !rx_end && resp_run && resp_cnt >= RESP_LIMIT;
    endsequence
    property p_r11;
        s_late_start ##1 (tx_hdr_valid && is_ack && !rx_end) |=> viol[V_R11];
    endproperty
    a_r11: assert property (p_r11) else $error("late response not caught"); // [R11]

    property p_r12;
        in_ctrl && tx_obj_valid |=> viol[V_R12];
    endproperty
    a_r12: assert property (p_r12) else $error("control payload not flagged"); // [R12]

    property p_r13;
        tx_hdr_valid && is_ping && !contract_present |=> viol[V_R13];
    endproperty
    a_r13: assert property (p_r13) else $error("ping without contract not flagged"); // [R13]

    property p_r14;
        ping_due |=> viol[V_R14] && (ping_cnt == 24'h0);
    endproperty
    a_r14: assert property (p_r14) else $error("ping watch overran its period"); // [R14]

    property p_r19;
        cap_obj && tx_obj[PDO_T_MSB:PDO_T_LSB] == 2'h3 |=> viol[V_R19];
    endproperty
    a_r19: assert property (p_r19) else $error("illegal object type not flagged"); // [R19]

    property p_r16;
        cap_obj && obj_idx == 3'h0 && tx_obj[VOLT_MSB:VOLT_LSB] != VOLT_5V |=> viol[V_R16];
    endproperty
    a_r16: assert property (p_r16) else $error("first object voltage not flagged"); // [R16]

    property p_r24;
        tx_hdr_valid && tx_sop && is_ctrl && tx_hdr[TYPE_MSB:TYPE_LSB] == 4'hE |=> viol[V_R24];
    endproperty
    a_r24: assert property (p_r24) else $error("reserved control type not flagged"); // [R24]
endmodule

// file: rtl/pdmfc_pdo_check.sv
module pdmfc_pdo_check
    import pdmfc_pkg::*;
(
    pdmfc_pdo_if.check p
);
    wire [1:0] kind = pdo_kind(p.obj);
    wire [1:0] prev_kind = pdo_kind(p.prev);
    wire is_fixed = kind == PDO_FIXED;
    wire is_range = (kind == PDO_BATTERY) || (kind == PDO_VARIABLE);
    // fixed < battery < variable, which is exactly the code order
    wire rank_back = kind < prev_kind;
    wire same_rank_not_rising = (kind == prev_kind) && (pdo_volt(p.obj) <= pdo_volt(p.prev));

    assign p.err_first = p.first && (!is_fixed || (p.obj[RSV_MSB:RSV_LSB] != 3'h0)
        || (pdo_volt(p.obj) != VOLT_5V)); // [R16]
    assign p.err_flags = p.first && (p.obj[FLG_MSB:FLG_LSB] != p.cap_flags); // [R17]
    assign p.err_fixed = is_fixed && ((p.obj[PEAK_MSB:PEAK_LSB] != p.expect_pdo[PEAK_MSB:PEAK_LSB])
        || (pdo_cur(p.obj) != pdo_cur(p.expect_pdo))); // [R18]
    assign p.err_kind = kind == PDO_ILLEGAL; // [R19]
    // strict rise also rules out two objects of one kind sharing a voltage
    assign p.err_order = p.has_prev && (rank_back || same_rank_not_rising); // [R20]
    assign p.err_fixed_rsv = is_fixed && !p.first && ((p.obj[FIX_RSV_MSB:RSV_LSB] != 8'h00)
        || (pdo_volt(p.obj) != pdo_volt(p.expect_pdo))); // [R21]
    assign p.err_range = is_range && ((p.obj[VMAX_MSB:VMAX_LSB] != p.expect_pdo[VMAX_MSB:VMAX_LSB])
        || (pdo_volt(p.obj) != pdo_volt(p.expect_pdo))
        || (pdo_cur(p.obj) != pdo_cur(p.expect_pdo))); // [R22]
endmodule

// file: rtl/pdmfc_pdo_if.sv
interface pdmfc_pdo_if;
    logic [31:0] obj;
    logic [31:0] prev;
    logic [31:0] expect_pdo;
    logic [4:0] cap_flags;
    logic first;
    logic has_prev;
    logic err_first;
    logic err_flags;
    logic err_fixed;
    logic err_kind;
    logic err_order;
    logic err_fixed_rsv;
    logic err_range;

    modport check (
        input obj, prev, expect_pdo, cap_flags, first, has_prev,
        output err_first, err_flags, err_fixed, err_kind, err_order, err_fixed_rsv, err_range
    );
    modport feed (
        output obj, prev, expect_pdo, cap_flags, first, has_prev,
        input err_first, err_flags, err_fixed, err_kind, err_order, err_fixed_rsv, err_range
    );
endinterface

// file: rtl/pdmfc_pkg.sv
package pdmfc_pkg;
    // message header field positions
    localparam int HDR_RSV_BIT = 15;
    localparam int NDO_MSB = 14;
    localparam int NDO_LSB = 12;
    localparam int ID_MSB = 11;
    localparam int ID_LSB = 9;
    localparam int ROLE_BIT = 8;
    localparam int REV_MSB = 7;
    localparam int REV_LSB = 6;
    localparam int DROLE_BIT = 5;
    localparam int RSV4_BIT = 4;
    localparam int TYPE_MSB = 3;
    localparam int TYPE_LSB = 0;

    localparam logic [2:0] NDO_NONE = 3'h0;
    localparam logic [3:0] MT_GOODCRC = 4'h1;
    localparam logic [3:0] MT_PING = 4'h5;
    localparam logic [3:0] MT_SRC_CAP = 4'h1;
    localparam logic [3:0] MT_RSV_LO = 4'h0;
    localparam logic [3:0] MT_RSV_E = 4'hE;
    localparam logic [3:0] MT_RSV_F = 4'hF;
    localparam logic [1:0] REV_ACK = 2'h1;
    localparam logic [1:0] REV_NEVER_BMC = 2'h0;

    // power data object field positions
    localparam int PDO_T_MSB = 31;
    localparam int PDO_T_LSB = 30;
    localparam int FLG_MSB = 29;
    localparam int FLG_LSB = 25;
    localparam int RSV_MSB = 24;
    localparam int RSV_LSB = 22;
    localparam int FIX_RSV_MSB = 29;
    localparam int PEAK_MSB = 21;
    localparam int PEAK_LSB = 20;
    localparam int VMAX_MSB = 29;
    localparam int VMAX_LSB = 20;
    localparam int VOLT_MSB = 19;
    localparam int VOLT_LSB = 10;
    localparam int CUR_MSB = 9;
    localparam int CUR_LSB = 0;

    localparam logic [1:0] PDO_FIXED = 2'h0;
    localparam logic [1:0] PDO_BATTERY = 2'h1;
    localparam logic [1:0] PDO_VARIABLE = 2'h2;
    localparam logic [1:0] PDO_ILLEGAL = 2'h3;
    // voltage code in 50 mV units
    localparam logic [9:0] VOLT_5V = 10'h064;

    localparam int MAX_OBJ = 7;
    localparam logic [2:0] OBJ_LAST = 3'h7;

    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RESP_NS = 195000;
    // a longest time, so rounded down
    localparam int RESP_LIMIT_CYC = T_RESP_NS / CLK_PERIOD_NS;
    localparam int T_PING_NS = 10000000;
    localparam int PING_PERIOD_CYC = T_PING_NS / CLK_PERIOD_NS;

    // violation flag positions
    localparam int V_R2 = 0;
    localparam int V_R3 = 1;
    localparam int V_R4 = 2;
    localparam int V_R5 = 3;
    localparam int V_R6 = 4;
    localparam int V_R7 = 5;
    localparam int V_R8 = 6;
    localparam int V_R9 = 7;
    localparam int V_R10 = 8;
    localparam int V_R11 = 9;
    localparam int V_R12 = 10;
    localparam int V_R13 = 11;
    localparam int V_R14 = 12;
    localparam int V_R15 = 13;
    localparam int V_R16 = 14;
    localparam int V_R17 = 15;
    localparam int V_R18 = 16;
    localparam int V_R19 = 17;
    localparam int V_R20 = 18;
    localparam int V_R21 = 19;
    localparam int V_R22 = 20;
    localparam int V_R23 = 21;
    localparam int V_R24 = 22;
    localparam int NVIOL = 23;

    function automatic logic [2:0] hdr_ndo(input logic [15:0] h);
        return h[NDO_MSB:NDO_LSB];
    endfunction

    function automatic logic [3:0] hdr_type(input logic [15:0] h);
        return h[TYPE_MSB:TYPE_LSB];
    endfunction

    function automatic logic [1:0] pdo_kind(input logic [31:0] p);
        return p[PDO_T_MSB:PDO_T_LSB];
    endfunction

    function automatic logic [9:0] pdo_volt(input logic [31:0] p);
        return p[VOLT_MSB:VOLT_LSB];
    endfunction

    function automatic logic [9:0] pdo_cur(input logic [31:0] p);
        return p[CUR_MSB:CUR_LSB];
    endfunction
endpackage
